/* File: pwm_meas_timers.sv */
// pwm general timer plus three secondary timers behind an apb slave
// assumes pins synchronous enough for a two-flop synchroniser, one clock
`timescale 1ns/1ns
`include "tmr_consts.svh"
module pwm_meas_timers (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic GENERAL_TIMER_TRIGGER_INPUT,
  input wire logic [2:0] SECONDARY_TIMER_EVENT_INPUT,
  output logic GENERAL_TIMER_WAVE_OUTPUT
);
  import tmr_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [3:0] start_q;
  logic [7:0] gmode_q;
  logic [7:0] smode_q [3];
  logic [15:0] greload_q;
  logic [15:0] gduty_q;
  logic [15:0] gpos_q;
  logic [7:0] gpre_q;
  gstate_type gstate_q;
  gstate_type gstate_d;
  logic wave_q;
  logic wave_d;
  logic girq_q;
  logic gtrig_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [8:0] div_q;
  logic [3:0] ticks;
  logic wr_en;
  logic setup;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic pwm_on;
  logic eight;
  logic gtick;
  logic trig_edge;
  logic pstep;
  logic [15:0] glast;
  logic [15:0] gwidth;
  sec_wr_type swr [3];
  sec_rd_type srd [3];

  // ****************************************
  // apb slave
  // ****************************************
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE & pready_q;

  // one-cycle access phase, read data caught at setup
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~rd_hit;
      if (setup)
        prdata_q <= (rd_hit & ~PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // read mux and address decode
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (PADDR)
      `A_START: rd_mux[3:0] = start_q;
      `A_GMODE: rd_mux[7:0] = gmode_q;
      `A_GDATA: rd_mux = 32'h0000_0000; // no usable value
      `A_GSTAT:
      begin
        rd_mux[`GS_IRQ] = girq_q;
        rd_mux[`GS_WAVE] = wave_q;
        rd_mux[`GS_RUN] = (gstate_q == G_RUN);
      end
      default:
      begin
        rd_hit = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
          if (PADDR[7:6] == 2'b00 && PADDR[5:4] == 2'(i + 1) && PADDR[1:0] == 2'b00)
          begin
            if (PADDR[3:2] == `S_MODE_IX)
            begin
              rd_hit = 1'b1;
              rd_mux[7:0] = smode_q[i];
              rd_mux[`MB_OVF] = srd[i].ovf;
            end
            else if (PADDR[3:2] == `S_DATA_IX)
            begin
              rd_hit = 1'b1;
              rd_mux[15:0] = srd[i].data;
            end
            else if (PADDR[3:2] == `S_STAT_IX)
            begin
              rd_hit = 1'b1;
              rd_mux[0] = srd[i].irq;
            end
          end
        end
      end
    endcase
  end

  // start flags and general mode register
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      start_q <= 4'h0;
      gmode_q <= 8'h00;
    end
    else if (wr_en)
    begin
      if (PADDR == `A_START)
        start_q <= PWDATA[3:0];
      if (PADDR == `A_GMODE)
        gmode_q <= PWDATA[7:0];
    end
  end

  // ****************************************
  // count source divider and synchronisers
  // ****************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      div_q <= 9'h000;
    else
      div_q <= div_q + 9'h001;
  end

  assign ticks[0] = ((div_q & `DIV_M0) == `DIV_M0);
  assign ticks[1] = ((div_q & `DIV_M1) == `DIV_M1);
  assign ticks[2] = ((div_q & `DIV_M2) == `DIV_M2);
  assign ticks[3] = ((div_q & `DIV_M3) == `DIV_M3);

  // two-flop synchronisers for all pins
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= {SECONDARY_TIMER_EVENT_INPUT, GENERAL_TIMER_TRIGGER_INPUT};
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // general timer in modulation mode
  // ****************************************
  assign pwm_on = &gmode_q[2:0];
  assign eight = gmode_q[`MB_8BIT];
  assign gtick = ticks[gmode_q[7:6]];
  assign trig_edge = gmode_q[`MB_EDGE] ? (sync2_q[0] & ~gtrig_q) :
                     (~sync2_q[0] & gtrig_q);
  assign pstep = eight ? (gtick & (gpre_q == 8'h00)) : gtick;
  assign glast = eight ? `PWM8_LAST : `PWM16_LAST;
  assign gwidth = eight ? {8'h00, greload_q[15:8]} : greload_q;

  // trigger pin history
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      gtrig_q <= 1'b0;
    else
      gtrig_q <= sync2_q[0];
  end

  // run state
  always_comb
  begin
    gstate_d = gstate_q;
    if (!pwm_on || !start_q[0])
      gstate_d = G_STOP;
    else
    begin
      unique case (gstate_q)
        G_STOP: gstate_d = gmode_q[`MB_EXT] ? G_WAIT : G_RUN;
        G_WAIT:
        begin
          if (trig_edge)
            gstate_d = G_RUN;
        end
        G_RUN: gstate_d = G_RUN; // triggers ignored
        default: gstate_d = G_STOP;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      gstate_q <= G_STOP;
    else
      gstate_q <= gstate_d;
  end

  // reload register: written at any time
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      greload_q <= 16'h0000;
    else if (wr_en && PADDR == `A_GDATA)
      greload_q <= PWDATA[15:0];
  end

  // counter side: width, position and prescaler
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
    begin
      gpos_q <= 16'h0000;
      gduty_q <= 16'h0000;
      gpre_q <= 8'h00;
    end
    else if (gstate_q != G_RUN)
    begin
      gpos_q <= 16'h0000;
      gduty_q <= gwidth; // halted counter follows reload
      gpre_q <= greload_q[7:0];
    end
    else
    begin
      if (eight && gtick)
        gpre_q <= (gpre_q == 8'h00) ? greload_q[7:0] : gpre_q - 8'h01;
      if (pstep)
      begin
        if (gpos_q == glast)
        begin
          gpos_q <= 16'h0000;
          gduty_q <= gwidth; // new width just before the rise
        end
        else
          gpos_q <= gpos_q + 16'h0001;
      end
    end
  end

  // wave is high for the first width steps of each cycle
  assign wave_d = (gstate_d == G_RUN) & (gstate_q == G_RUN) & (gpos_q < gduty_q);

  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      wave_q <= 1'b0;
    else
      wave_q <= wave_d;
  end

  // request on each falling wave edge except one caused by a stop, set wins over clear
  always_ff @(posedge SYS_CLK)
  begin
    if (!RSTN)
      girq_q <= 1'b0;
    else if (gstate_q == G_RUN && gstate_d == G_RUN && wave_q && !wave_d) // none on stop
      girq_q <= 1'b1;
    else if (wr_en && PADDR == `A_GSTAT && PWDATA[`GS_IRQ])
      girq_q <= 1'b0;
  end

  // ****************************************
  // secondary timers
  // ****************************************
  for (genvar i = 0; i < 3; i++)
  begin : g_sec
    logic slot;
    assign slot = (PADDR[7:6] == 2'b00) && (PADDR[5:4] == 2'(i + 1)) &&
                  (PADDR[1:0] == 2'b00);
    assign swr[i].mode_we = wr_en & slot & (PADDR[3:2] == `S_MODE_IX);
    assign swr[i].data_we = wr_en & slot & (PADDR[3:2] == `S_DATA_IX);
    assign swr[i].clr_we = wr_en & slot & (PADDR[3:2] == `S_STAT_IX) & PWDATA[0];
    assign swr[i].wdata = PWDATA[15:0];

    // mode register
    always_ff @(posedge SYS_CLK)
    begin
      if (!RSTN)
        smode_q[i] <= 8'h00;
      else if (swr[i].mode_we)
        smode_q[i] <= PWDATA[7:0];
    end

    sec_timer u_sec (
      .clk(SYS_CLK),
      .rst_n(RSTN),
      .mode(smode_q[i]),
      .run(start_q[i + 1]),
      .ticks(ticks),
      .pin_s(sync2_q[i + 1]),
      .wr(swr[i]),
      .rd(srd[i])
    );
  end

  // ****************************************
  // outputs
  // ****************************************
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign GENERAL_TIMER_WAVE_OUTPUT = wave_q;
endmodule

/* File: tmr_consts.svh */
// constants of the pwm and measurement timer block
// assumes byte addresses on an 8-bit apb address, one word per register
// Notes on behaviour
// - general timer runs pulse width modulation when mode bits 2:0 are all one
// - mode bit 5 low gives 16-bit modulator, high gives 8-bit with prescaler
// - software trigger: setting start flag starts modulation and drives the wave
// - external trigger: modulation starts on trigger pin edge while start flag is one
// - trigger edge is falling with mode bit 3 low, rising with it high
// - write while halted loads both reload register and counter
// - once started the wave runs continuously and further triggers are ignored
// - 16-bit: high for m clock periods, cycle of 2^16-1 clock periods
// - request bit of general timer sets at every falling edge of the wave; not set when a stop ends the pulse
// - reload copied into counter just before next rise; new width next pulse
// - reading the general timer data in modulation gives undefined data
// - 8-bit: low byte is prescaler on selected clock, high byte is modulator
// - prescaler reloads from low byte n at zero, period n+1 clock periods
// - 8-bit: high for (n+1)*m, cycle of (n+1)*(2^8-1) clock periods
// - secondary mode bits 1:0: 00 timer, 01 event count, 10 measurement
// - timer mode counts selected clock only while start flag is one
// - timer mode counts down; at zero sets request, reloads, keeps counting
// - halted write loads reload and counter; running write loads reload only
// - event mode counts pin edges: 00 falling, 01 rising, 10 both
// - mode bit 3 low measures period; result kept in reload register
// - bit 2 low measures falling to falling, high rising to rising
// - on measured edge counter goes to reload, counter clears, counting resumes
// - request set after each transfer except first after start flag set
// - mode bit 3 high measures width, edge to opposite edge
// - in measurement mode a read returns the reload register
// - mode bit 5 is overflow flag: set at zero, cleared by mode write, one at reset
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// register addresses
`define A_START 8'h00
`define A_GMODE 8'h04
`define A_GDATA 8'h08
`define A_GSTAT 8'h0c
// secondary slots at 0x10, 0x20, 0x30; word index inside a slot
`define S_MODE_IX 2'h0
`define S_DATA_IX 2'h1
`define S_STAT_IX 2'h2

// mode bit positions
`define MB_SEL2 2
`define MB_EDGE 3
`define MB_EXT 4
`define MB_8BIT 5
`define MB_OVF 5
`define SM_TIMER 2'b00
`define SM_EVENT 2'b01
`define SM_MEAS 2'b10

// status bits
`define GS_IRQ 0
`define GS_WAVE 1
`define GS_RUN 2

// modulator wrap points
`define PWM16_LAST 16'hfffe
`define PWM8_LAST 16'h00fe

// count source divider masks: /2 /16 /64 /512
`define DIV_M0 9'h001
`define DIV_M1 9'h00f
`define DIV_M2 9'h03f
`define DIV_M3 9'h1ff

`define OVF_RST 1'b1

`endif

/* File: tmr_pkg.sv */
// types shared by the timer block
// assumes tmr_consts.svh supplies the numbers
package tmr_pkg;

  typedef enum logic [1:0] {
    G_STOP = 2'b00,
    G_WAIT = 2'b01,
    G_RUN = 2'b10
  } gstate_type;

  typedef struct packed {
    logic mode_we;
    logic data_we;
    logic clr_we;
    logic [15:0] wdata;
  } sec_wr_type;

  typedef struct packed {
    logic [15:0] data;
    logic ovf;
    logic irq;
  } sec_rd_type;

endpackage

/* File: sec_timer.sv */
// one secondary timer: timer, event count and measurement modes
// assumes a synchronised pin level and one-cycle count source enables
`timescale 1ns/1ns
`include "tmr_consts.svh"
module sec_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] mode,
  input wire logic run,
  input wire logic [3:0] ticks,
  input wire logic pin_s,
  input tmr_pkg::sec_wr_type wr,
  output tmr_pkg::sec_rd_type rd
);
  import tmr_pkg::*;

  logic [15:0] cnt_q;
  logic [15:0] rel_q;
  logic pin_q;
  logic first_q;
  logic irq_q;
  logic ovf_q;
  logic tick;
  logic rise;
  logic fall;
  logic ev;
  logic is_meas;
  logic meas_edge;
  logic down_step;
  logic wrap;
  logic meas_hit;
  logic meas_roll;

  // ****************************************
  // step and edge decode
  // ****************************************
  assign tick = ticks[mode[7:6]];
  assign rise = pin_s & ~pin_q;
  assign fall = ~pin_s & pin_q;
  assign is_meas = (mode[1:0] == `SM_MEAS);
  assign ev = (mode[3:2] == 2'b00) ? fall :
              (mode[3:2] == 2'b01) ? rise :
              (mode[3:2] == 2'b10) ? (rise | fall) : 1'b0;
  // width: any edge; period: like edges
  assign meas_edge = mode[`MB_EDGE] ? (rise | fall) :
                     (mode[`MB_SEL2] ? rise : fall);
  assign down_step = run & (((mode[1:0] == `SM_TIMER) & tick) |
                     ((mode[1:0] == `SM_EVENT) & ev));
  assign wrap = down_step & (cnt_q == 16'h0000);
  assign meas_hit = is_meas & run & meas_edge;
  assign meas_roll = is_meas & run & tick & ~meas_edge & (&cnt_q);

  // pin history for edges
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pin_q <= 1'b0;
    else
      pin_q <= pin_s;
  end

  // counter and reload register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= 16'h0000;
      rel_q <= 16'h0000;
    end
    else if (wr.data_we & ~run)
    begin
      cnt_q <= wr.wdata;
      rel_q <= wr.wdata;
    end
    else
    begin
      if (wr.data_we)
        rel_q <= wr.wdata;
      if (meas_hit)
      begin
        // a tick on the edge cycle closes the old span, so no tick is lost
        rel_q <= tick ? cnt_q + 16'h0001 : cnt_q;
        cnt_q <= 16'h0000;
      end
      else if (is_meas & run & tick)
        cnt_q <= cnt_q + 16'h0001;
      else if (wrap)
        cnt_q <= rel_q;
      else if (down_step)
        cnt_q <= cnt_q - 16'h0001;
    end
  end

  // first transfer after start is silent
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      first_q <= 1'b1;
    else if (!run)
      first_q <= 1'b1;
    else if (meas_hit)
      first_q <= 1'b0;
  end

  // request flag, set wins over clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else if (wrap | (meas_hit & ~first_q))
      irq_q <= 1'b1;
    else if (wr.clr_we)
      irq_q <= 1'b0;
  end

  // overflow flag, set wins over mode write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ovf_q <= `OVF_RST;
    else if (wrap | meas_roll)
      ovf_q <= 1'b1;
    else if (wr.mode_we)
      ovf_q <= 1'b0;
  end

  assign rd.data = is_meas ? rel_q : cnt_q;
  assign rd.ovf = ovf_q;
  assign rd.irq = irq_q;
endmodule

/* File: pwm_meas_timers_checker.sv */
// assertions on the ports of the pwm and measurement timer block
// assumes it is bound to pwm_meas_timers and sees only its ports
`timescale 1ns/1ns
module pwm_meas_timers_checker (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic GENERAL_TIMER_TRIGGER_INPUT,
  input wire logic [2:0] SECONDARY_TIMER_EVENT_INPUT,
  input wire logic GENERAL_TIMER_WAVE_OUTPUT
);
  // ****
  // bus and wave properties
  // ****
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // setup cycle and answered read of one address
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence rd_s(a);
    PREADY && !PWRITE && PADDR == a;
  endsequence
  ready_next_a:
    assert property (setup_s |=> PREADY) else $error("no ready after setup");
  ready_pulse_a:
    assert property (PREADY |=> !PREADY) else $error("ready held too long");
  err_align_a:
    assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR) else $error("misaligned taken");
  err_zero_a:
    assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("err data");
  gdata_undef_a:
    assert property (rd_s(8'h08) |-> PRDATA == 32'h0) else $error("general data read");
  start_bits_a:
    assert property (rd_s(8'h00) |-> PRDATA[31:4] == 28'h0) else $error("start upper bits");
  wave_rst_a:
    assert property (disable iff (1'b0) !RSTN |=> !GENERAL_TIMER_WAVE_OUTPUT)
      else $error("wave high in reset");
  wave_min_a:
    assert property ($rose(GENERAL_TIMER_WAVE_OUTPUT) |-> GENERAL_TIMER_WAVE_OUTPUT[*2])
      else $error("wave pulse too short");
endmodule

bind pwm_meas_timers pwm_meas_timers_checker u_pwm_meas_timers_checker (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .GENERAL_TIMER_TRIGGER_INPUT(GENERAL_TIMER_TRIGGER_INPUT),
  .SECONDARY_TIMER_EVENT_INPUT(SECONDARY_TIMER_EVENT_INPUT),
  .GENERAL_TIMER_WAVE_OUTPUT(GENERAL_TIMER_WAVE_OUTPUT)
);

/* File: pin_source.sv */
// far side model: trigger and event pins as square waves
// assumes en is driven just after a rising clock edge
`timescale 1ns/1ns
module pin_source #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic [3:0] en,
  output logic [3:0] pins
);
  int cnt_q [4];
  logic [3:0] lvl_q = 4'h0;
  // an enabled pin toggles every HALF clocks, a disabled one holds
  always_ff @(posedge clk)
    for (int i = 0; i < 4; i++)
      if (!en[i])
        cnt_q[i] <= 0;
      else if (cnt_q[i] == HALF - 1)
      begin
        cnt_q[i] <= 0;
        lvl_q[i] <= !lvl_q[i];
      end
      else
        cnt_q[i] <= cnt_q[i] + 1;
  assign pins = lvl_q;
endmodule

/* File: pwm_and_measurement_timers_test.sv */
// self-checking bench for the pwm and measurement timer block
// assumes pin_source on the pins and the checker bound to the design
`timescale 1ns/1ns
`include "tmr_consts.svh"
module pwm_and_measurement_timers_test;
  localparam int HALF = 8;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wave;
  logic [3:0] en = 4'h0;
  logic [3:0] pins;
  logic [31:0] rv;
  logic ev;
  int error_cnt = 0;
  int n_checks = 0;
  int hi;
  int lo;
  pwm_meas_timers u_pwm_meas_timers (
    .SYS_CLK(sys_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .GENERAL_TIMER_TRIGGER_INPUT(pins[3]), .SECONDARY_TIMER_EVENT_INPUT(pins[2:0]),
    .GENERAL_TIMER_WAVE_OUTPUT(wave)
  );
  pin_source #(.HALF(HALF)) u_pin_source (.clk(sys_clk), .en(en), .pins(pins));
  // ****
  // helpers
  // ****
  initial
    forever #5 sys_clk = ~sys_clk;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // far side toggles chosen pins k times, then settles
  task automatic burst(input logic [3:0] m, input int k);
    en <= m;
    repeat (k * HALF) @(posedge sys_clk);
    en <= 4'h0;
    repeat (6) @(posedge sys_clk);
  endtask
  // cycles the wave stays at one level
  task automatic gap(input logic lvl, output int n);
    for (n = 0; n < 4000 && wave === lvl; n++)
      @(posedge sys_clk);
    if (n == 4000)
      chk("wave_gap", n, 0);
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_reset;
    rd(`A_START);
    chk("start", rv, 32'h0);
    for (int i = 1; i < 4; i++)
    begin
      rd(8'(i * 16));
      chk("ovf_rst", rv, 32'h20);
    end
    rd(8'h40);
    chk("unmapped", {ev, rv[30:0]}, 32'h80000000);
    wr(8'h10, 32'h0);
    rd(8'h10);
    chk("ovf_clr", rv, 32'h0);
    $display("reset test done");
  endtask
  task automatic test_event;
    logic [7:0] code [3] = '{8'h01, 8'h05, 8'h09};
    logic [31:0] n [3] = '{32'd8, 32'd8, 32'd16};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h10, {24'h0, code[i]});
      wr(8'h14, 32'd100);
      rd(8'h14);
      chk("ev_load", rv, 32'd100);
      wr(`A_START, 32'h2);
      burst(4'h1, 16);
      wr(`A_START, 32'h0);
      rd(8'h14);
      chk("ev_count", rv, 32'd100 - n[i]);
    end
    $display("event test done");
  endtask
  task automatic test_timer;
    // event mode with an idle pin holds the count, so a running write shows clearly
    wr(8'h30, 32'h01);
    wr(8'h34, 32'h3);
    wr(`A_START, 32'h8);
    wr(8'h34, 32'h7);
    rd(8'h34);
    chk("run_wr", rv, 32'h3);
    wr(8'h30, 32'h0);
    repeat (40) @(posedge sys_clk);
    wr(`A_START, 32'h0);
    rd(8'h38);
    chk("tm_req", rv[0], 1);
    rd(8'h30);
    chk("tm_ovf", rv[5], 1);
    rd(8'h34);
    hi = rv;
    repeat (20) @(posedge sys_clk);
    rd(8'h34);
    chk("tm_hold", rv, hi);
    wr(8'h38, 32'h1);
    rd(8'h38);
    chk("req_clr", rv[0], 0);
    $display("timer test done");
  endtask
  task automatic test_meas;
    logic [7:0] code [3] = '{8'h02, 8'h06, 8'h0a};
    logic [31:0] n [3] = '{HALF, HALF, HALF / 2};
    wr(8'h20, 32'h02);
    wr(`A_START, 32'h4);
    burst(4'h2, 2);
    rd(8'h28);
    chk("first_req", rv[0], 0);
    for (int i = 0; i < 3; i++)
    begin
      wr(`A_START, 32'h0);
      wr(8'h20, {24'h0, code[i]});
      wr(8'h28, 32'h1);
      wr(`A_START, 32'h4);
      burst(4'h2, 12);
      rd(8'h24);
      chk("meas", rv, n[i]);
      rd(8'h28);
      chk("meas_req", rv[0], 1);
    end
    wr(`A_START, 32'h0);
    $display("measure test done");
  endtask
  task automatic test_pwm;
    wr(`A_GMODE, 32'h27);
    wr(`A_GDATA, 32'h0301);
    wr(`A_START, 32'h1);
    repeat (2)
    begin
      gap(1'b1, lo);
      gap(1'b0, lo);
    end
    gap(1'b1, hi);
    gap(1'b0, lo);
    chk("pwm8_hi", hi, 12);
    chk("pwm8_lo", lo, 1008);
    wr(`A_GDATA, 32'h0201);
    gap(1'b1, lo);
    gap(1'b0, lo);
    gap(1'b1, hi);
    chk("pwm8_new", hi, 8);
    rd(`A_GSTAT);
    chk("pwm_req", rv[0], 1);
    wr(`A_START, 32'h0);
    wr(`A_GMODE, 32'h07);
    wr(`A_GDATA, 32'h5);
    wr(`A_START, 32'h1);
    gap(1'b0, lo);
    gap(1'b1, hi);
    chk("pwm16_hi", hi >= 9 && hi <= 11, 1);
    wr(`A_START, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      wr(`A_GMODE, i ? 32'h37 : 32'h3f);
      wr(`A_START, 32'h1);
      repeat (20) @(posedge sys_clk);
      rd(`A_GSTAT);
      chk("ext_wait", rv[2], 0);
      burst(4'h8, 1);
      rd(`A_GSTAT);
      chk("ext_run", rv[2], 1);
      wr(`A_START, 32'h0);
    end
    $display("pwm test done");
  endtask
  // counts, verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end
  // reset, then the scenarios
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    test_reset();
    test_event();
    test_timer();
    test_meas();
    test_pwm();
    stop_test();
  end
endmodule
